/* File: hw/refclk_out_regs.svh */
// Register offsets, field positions, reset values and constants of the clock output block
`ifndef REFCLK_OUT_REGS_SVH
`define REFCLK_OUT_REGS_SVH

// ==========================================================================
// Register byte offsets
`define RCO_CTRL_OFS          8'h00
`define RCO_TRIG_OFS          8'h04
`define RCO_SYSREF_OFS        8'h08
`define RCO_STATUS_OFS        8'h0c

// ==========================================================================
// Output control register fields
`define RCO_CTRL_REPEAT_EN    0
`define RCO_CTRL_OVERRIDE     1
`define RCO_CTRL_OVR_FLAG_EN  2
`define RCO_CTRL_C_MODE_LO    4
`define RCO_CTRL_D_MODE_LO    6
`define RCO_CTRL_RST          8'h01

// ==========================================================================
// Trigger output control register fields
`define RCO_TRIG_EN           0
`define RCO_TRIG_MODE_LO      1
`define RCO_TRIG_DIV_LO       8
`define RCO_TRIG_EN_RST       1'b0
`define RCO_TRIG_MODE_RST     2'h0
`define RCO_TRIG_DIV_RST      8'h04
`define RCO_TRIG_MODE_TSTAMP  2'h3

// ==========================================================================
// Timing reference capture fields
`define RCO_SYSREF_SEL_LO     0
`define RCO_SYSREF_SEL_RST    4'h0

// ==========================================================================
// Status register fields
`define RCO_ST_REPEAT         0
`define RCO_ST_C_FUNC_LO      1
`define RCO_ST_D_FUNC_LO      4
`define RCO_ST_TRIG           7
`define RCO_ST_STRAPS_LO      8
`define RCO_ST_SYSREF_CNT_LO  16

`endif

/* File: hw/refclk_out_pkg.sv */
// Types shared by the clock output block
`default_nettype none
package refclk_out_pkg;

    // ======================================================================
    // Function driven onto a CMOS auxiliary pin
    typedef enum logic [2:0] {
        AUX_OFF,
        AUX_OVR,
        AUX_REF,
        AUX_REF2,
        AUX_REF4
    } aux_func_t;

    // ======================================================================
    // Output control register
    typedef struct packed {
        logic [1:0] aux_d_mode;
        logic [1:0] aux_c_mode;
        logic       overrange_flag_enable;
        logic       strap_override_enable;
        logic       ref_repeat_enable;
    } ctrl_t;

    // ======================================================================
    // Trigger output control register
    typedef struct packed {
        logic [7:0] rx_div;
        logic [1:0] mode;
        logic       enable;
    } trig_ctrl_t;

    // ======================================================================
    // Over-range flags of channels C and D
    typedef struct packed {
        logic ch_d;
        logic ch_c;
    } overrange_t;

endpackage : refclk_out_pkg
`default_nettype wire

/* File: hw/ref_div_counter.sv */
// Divide-by-2 and divide-by-4 counter stepped by reference rising edges
`timescale 1ns/1ps
`default_nettype none
module ref_div_counter #(
    parameter int WIDTH = 2
) (
    // Clock and reset
    input  wire logic clk_i,
    input  wire logic rst_i,
    input  wire logic ce_i,
    // Control
    input  wire logic en_i,
    input  wire logic ref_rise_i,
    // Divided clocks
    output logic      div2_o,
    output logic      div4_o
);

    logic [WIDTH-1:0] cnt_r;

    // ======================================================================
    // Counter starts cleared so both halves begin low on enable
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cnt_r <= '0;
        end else if (ce_i) begin
            if (!en_i) begin
                cnt_r <= '0; // RL20
            end else if (ref_rise_i) begin
                cnt_r <= cnt_r + WIDTH'(1); // RL20
            end
        end
    end

    assign div2_o = cnt_r[0];
    assign div4_o = cnt_r[1];

    // ======================================================================
    // Checks
    property p_div_clear;
        @(posedge clk_i) disable iff (rst_i)
        ce_i && !en_i |=> cnt_r == '0;
    endproperty
    a_div_clear: assert property (p_div_clear) else $error("divider not cleared"); // RL20

    property p_div_step;
        @(posedge clk_i) disable iff (rst_i)
        ce_i && en_i && ref_rise_i |=> cnt_r == $past(cnt_r) + WIDTH'(1);
    endproperty
    a_div_step: assert property (p_div_step) else $error("divider missed edge"); // RL20

endmodule : ref_div_counter
`default_nettype wire

/* File: hw/ref_clock_output_select.sv */
// Reference repeat, trigger clock and CMOS auxiliary output selection
// Functional notes
// RL1 - Repeat output follows selected reference input
// RL2 - Repeat on with PLL, software can disable
// RL3 - Repeat needs PLL pin high, power-down low
// RL4 - Trigger source: timestamp or divided SerDes clock
// RL5 - Trigger output off until software enables it
// RL6 - Trigger frequency is lane rate over divider
// RL7 - CMOS outputs live at power-up; power-down kills
// RL8 - Straps enable both, divider only for C
// RL9 - Reference functions beat over-range flag
// RL10 - D reference needs nonzero C mode
// RL11 - Strap codes decode C off/flag/ref/half/quarter
// RL12 - Override modes decode C same way
// RL13 - D straps give ref; override as C
// RL14 - Timing reference comes from a separate source
// RL15 - Capture timing reference on deterministic edge
// RL16 - Windowed capture replaces fixed setup/hold
// RL17 - Accept single pulse or periodic reference
// RL18 - Periodic reference rate set by link format
// RL19 - PLL pin enables; select pin chooses input
// RL20 - Half/quarter from cleared reference-edge counters
//
// Decided for this implementation: the Wishbone register port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "refclk_out_regs.svh"
module ref_clock_output_select #(
    parameter bit QUAD_PART   = 1'b1,
    parameter int SYSREF_TAPS = 16
) (
    // Clock, reset and clock enable
    input  wire logic                    clk_i,
    input  wire logic                    rst_i,
    input  wire logic                    ce_i,
    // Wishbone slave
    input  wire logic                    cyc_i,
    input  wire logic                    stb_i,
    input  wire logic                    we_i,
    input  wire logic [7:0]              adr_i,
    input  wire logic [3:0]              sel_i,
    input  wire logic [31:0]             dat_i,
    output logic      [31:0]             dat_o,
    output logic                         ack_o,
    // Device pins
    input  wire logic                    pll_enable_pin_i,
    input  wire logic                    ref_input_select_pin_i,
    input  wire logic                    power_down_pin_i,
    input  wire logic [1:0]              clock_config_straps_i,
    // Clock and event inputs
    input  wire logic                    diff_ref_in_i,
    input  wire logic                    single_ended_ref_in_i,
    input  wire logic                    timestamp_in_i,
    input  wire logic                    serdes_tick_i,
    input  wire logic                    sysref_i,
    input  wire refclk_out_pkg::overrange_t overrange_i,
    // Clock outputs
    output logic                         ref_repeat_out_o,
    output logic                         trig_clock_out_o,
    output logic                         aux_out_c_o,
    output logic                         aux_out_d_o,
    output logic                         sysref_capture_o
);

    refclk_out_pkg::ctrl_t      ctrl_r;
    refclk_out_pkg::trig_ctrl_t trig_r;
    refclk_out_pkg::aux_func_t  c_func_r;
    refclk_out_pkg::aux_func_t  d_func_r;
    refclk_out_pkg::aux_func_t  c_func_nxt;
    refclk_out_pkg::aux_func_t  d_func_nxt;
    logic [3:0]                 sysref_sel_r;
    logic                       ack_r;
    logic [31:0]                rdat_r;
    logic                       ref_sel;
    logic                       ref_prev_r;
    logic                       ref_rise;
    logic                       div_en;
    logic                       div2;
    logic                       div4;
    logic [1:0]                 c_code;
    logic [1:0]                 d_code;
    logic                       ts_r;
    logic [7:0]                 trig_cnt_r;
    logic [SYSREF_TAPS-1:0]     sysref_line_r;
    logic                       sysref_tap;
    logic                       sysref_prev_r;
    logic [7:0]                 sysref_cnt_r;
    logic                       acc;
    logic                       wr;

    // ======================================================================
    // Wishbone slave: registered ack, one wait state, unmapped reads zero
    assign acc = cyc_i && stb_i && !ack_r;
    assign wr  = acc && we_i;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_r <= 1'b0;
        end else if (ce_i) begin
            ack_r <= acc;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_r <= refclk_out_pkg::ctrl_t'(`RCO_CTRL_RST);
        end else if (ce_i && wr && adr_i == `RCO_CTRL_OFS && sel_i[0]) begin
            ctrl_r.ref_repeat_enable     <= dat_i[`RCO_CTRL_REPEAT_EN]; // RL2
            ctrl_r.strap_override_enable <= dat_i[`RCO_CTRL_OVERRIDE];
            ctrl_r.overrange_flag_enable <= dat_i[`RCO_CTRL_OVR_FLAG_EN];
            ctrl_r.aux_c_mode            <= dat_i[`RCO_CTRL_C_MODE_LO +: 2];
            ctrl_r.aux_d_mode            <= dat_i[`RCO_CTRL_D_MODE_LO +: 2];
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            trig_r.enable <= `RCO_TRIG_EN_RST; // RL5
            trig_r.mode   <= `RCO_TRIG_MODE_RST;
            trig_r.rx_div <= `RCO_TRIG_DIV_RST;
        end else if (ce_i && wr && adr_i == `RCO_TRIG_OFS) begin
            if (sel_i[0]) begin
                trig_r.enable <= dat_i[`RCO_TRIG_EN];
                trig_r.mode   <= dat_i[`RCO_TRIG_MODE_LO +: 2];
            end
            if (sel_i[1]) begin
                trig_r.rx_div <= dat_i[`RCO_TRIG_DIV_LO +: 8];
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sysref_sel_r <= `RCO_SYSREF_SEL_RST;
        end else if (ce_i && wr && adr_i == `RCO_SYSREF_OFS && sel_i[0]) begin
            sysref_sel_r <= dat_i[`RCO_SYSREF_SEL_LO +: 4]; // RL16
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rdat_r <= 32'h0;
        end else if (ce_i) begin
            rdat_r <= 32'h0;
            if (acc && !we_i) begin
                unique case (adr_i)
                    `RCO_CTRL_OFS: begin
                        rdat_r[`RCO_CTRL_REPEAT_EN]     <= ctrl_r.ref_repeat_enable;
                        rdat_r[`RCO_CTRL_OVERRIDE]      <= ctrl_r.strap_override_enable;
                        rdat_r[`RCO_CTRL_OVR_FLAG_EN]   <= ctrl_r.overrange_flag_enable;
                        rdat_r[`RCO_CTRL_C_MODE_LO +: 2] <= ctrl_r.aux_c_mode;
                        rdat_r[`RCO_CTRL_D_MODE_LO +: 2] <= ctrl_r.aux_d_mode;
                    end
                    `RCO_TRIG_OFS: begin
                        rdat_r[`RCO_TRIG_EN]            <= trig_r.enable;
                        rdat_r[`RCO_TRIG_MODE_LO +: 2]  <= trig_r.mode;
                        rdat_r[`RCO_TRIG_DIV_LO +: 8]   <= trig_r.rx_div;
                    end
                    `RCO_SYSREF_OFS: begin
                        rdat_r[`RCO_SYSREF_SEL_LO +: 4] <= sysref_sel_r;
                    end
                    `RCO_STATUS_OFS: begin
                        rdat_r[`RCO_ST_REPEAT]           <= ref_repeat_out_o;
                        rdat_r[`RCO_ST_C_FUNC_LO +: 3]   <= c_func_r;
                        rdat_r[`RCO_ST_D_FUNC_LO +: 3]   <= d_func_r;
                        rdat_r[`RCO_ST_TRIG]             <= trig_r.enable;
                        rdat_r[`RCO_ST_STRAPS_LO +: 2]   <= clock_config_straps_i;
                        rdat_r[`RCO_ST_SYSREF_CNT_LO +: 8] <= sysref_cnt_r;
                    end
                    default: begin
                        rdat_r <= 32'h0;
                    end
                endcase
            end
        end
    end

    assign ack_o = ack_r;
    assign dat_o = rdat_r;

    // ======================================================================
    // Reference repeat output
    // Select pin low picks the differential input, high the single-ended one
    assign ref_sel = ref_input_select_pin_i ? single_ended_ref_in_i : diff_ref_in_i; // RL19

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ref_repeat_out_o <= 1'b0;
        end else if (ce_i) begin
            // Power-down wins so the board cannot keep this clock alive in it
            ref_repeat_out_o <= pll_enable_pin_i && !power_down_pin_i // RL3
                                && ctrl_r.ref_repeat_enable && ref_sel; // RL1 RL2
        end
    end

    // ======================================================================
    // Divided reference for the CMOS pins
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ref_prev_r <= 1'b0;
        end else if (ce_i) begin
            ref_prev_r <= ref_sel;
        end
    end

    assign ref_rise = ref_sel && !ref_prev_r;
    assign div_en   = !power_down_pin_i
                      && (c_func_r == refclk_out_pkg::AUX_REF2
                          || c_func_r == refclk_out_pkg::AUX_REF4
                          || d_func_r == refclk_out_pkg::AUX_REF2
                          || d_func_r == refclk_out_pkg::AUX_REF4);

    ref_div_counter #(
        .WIDTH      (2)
    ) u_div (
        .clk_i      (clk_i),
        .rst_i      (rst_i),
        .ce_i       (ce_i),
        .en_i       (div_en),
        .ref_rise_i (ref_rise),
        .div2_o     (div2),
        .div4_o     (div4)
    );

    // ======================================================================
    // CMOS pin function decode
    // Straps set both enables but carry a divider only for pin C
    assign c_code = ctrl_r.strap_override_enable ? ctrl_r.aux_c_mode
                                                 : clock_config_straps_i; // RL8 RL11 RL12
    assign d_code = ctrl_r.strap_override_enable ? ctrl_r.aux_d_mode
                  : {1'b0, |clock_config_straps_i}; // RL8 RL13

    function automatic refclk_out_pkg::aux_func_t decode_func(
        input logic [1:0] code,
        input logic       flag_en
    );
        refclk_out_pkg::aux_func_t f;
        // Clock codes are tested first, flag only when the code is zero
        unique case (code)
            2'h1: f = refclk_out_pkg::AUX_REF; // RL9
            2'h2: f = refclk_out_pkg::AUX_REF2;
            2'h3: f = refclk_out_pkg::AUX_REF4;
            2'h0: f = (flag_en && QUAD_PART) ? refclk_out_pkg::AUX_OVR
                                              : refclk_out_pkg::AUX_OFF;
        endcase
        return f;
    endfunction : decode_func

    always_comb begin
        c_func_nxt = refclk_out_pkg::AUX_OFF;
        d_func_nxt = refclk_out_pkg::AUX_OFF;
        if (!power_down_pin_i) begin // RL7
            c_func_nxt = decode_func(c_code, ctrl_r.overrange_flag_enable); // RL11 RL12
            // Pin D carries a reference only while pin C does
            d_func_nxt = decode_func((c_code != 2'h0) ? d_code : 2'h0, // RL10
                                     ctrl_r.overrange_flag_enable); // RL13
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            c_func_r <= refclk_out_pkg::AUX_OFF;
            d_func_r <= refclk_out_pkg::AUX_OFF;
        end else if (ce_i) begin
            c_func_r <= c_func_nxt;
            d_func_r <= d_func_nxt;
        end
    end

    function automatic logic aux_level(
        input refclk_out_pkg::aux_func_t f,
        input logic                      flag,
        input logic                      ref_lvl,
        input logic                      d2,
        input logic                      d4
    );
        logic v;
        unique case (f)
            refclk_out_pkg::AUX_OFF:  v = 1'b0;
            refclk_out_pkg::AUX_OVR:  v = flag;
            refclk_out_pkg::AUX_REF:  v = ref_lvl;
            refclk_out_pkg::AUX_REF2: v = d2;
            refclk_out_pkg::AUX_REF4: v = d4;
            default:                  v = 1'b0;
        endcase
        return v;
    endfunction : aux_level

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            aux_out_c_o <= 1'b0;
            aux_out_d_o <= 1'b0;
        end else if (ce_i) begin
            aux_out_c_o <= !power_down_pin_i // RL7
                           && aux_level(c_func_r, overrange_i.ch_c, ref_sel, div2, div4);
            aux_out_d_o <= !power_down_pin_i
                           && aux_level(d_func_r, overrange_i.ch_d, ref_sel, div2, div4);
        end
    end

    // ======================================================================
    // Trigger / clock output
    // A divider of zero or one leaves the output low: no half period exists
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ts_r       <= 1'b0;
            trig_cnt_r <= 8'h0;
        end else if (ce_i) begin
            ts_r <= timestamp_in_i;
            if (!trig_r.enable || trig_r.mode == `RCO_TRIG_MODE_TSTAMP) begin
                trig_cnt_r <= 8'h0;
            end else if (serdes_tick_i) begin
                trig_cnt_r <= (trig_cnt_r + 8'h1 >= trig_r.rx_div) ? 8'h0 // RL6
                              : trig_cnt_r + 8'h1;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            trig_clock_out_o <= 1'b0;
        end else if (ce_i) begin
            if (!trig_r.enable) begin
                trig_clock_out_o <= 1'b0; // RL5
            end else if (trig_r.mode == `RCO_TRIG_MODE_TSTAMP) begin
                trig_clock_out_o <= ts_r; // RL4
            end else begin
                trig_clock_out_o <= trig_cnt_r < {1'b0, trig_r.rx_div[7:1]}; // RL4 RL6
            end
        end
    end

    // ======================================================================
    // Timing reference capture through a selectable delay window
    // Source separation and rate are the system's duty; any rising edge is accepted
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sysref_line_r <= '0;
            sysref_prev_r <= 1'b0;
            sysref_cnt_r  <= 8'h0;
        end else if (ce_i) begin
            sysref_line_r <= {sysref_line_r[SYSREF_TAPS-2:0], sysref_i}; // RL16
            sysref_prev_r <= sysref_tap;
            if (sysref_tap && !sysref_prev_r) begin
                sysref_cnt_r <= sysref_cnt_r + 8'h1; // RL17
            end
        end
    end

    assign sysref_tap = sysref_line_r[sysref_sel_r];

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sysref_capture_o <= 1'b0;
        end else if (ce_i) begin
            sysref_capture_o <= sysref_tap && !sysref_prev_r; // RL15 RL17
        end
    end

    // ======================================================================
    // Checks
    property p_repeat_pd;
        @(posedge clk_i) disable iff (rst_i)
        ce_i && power_down_pin_i |=> !ref_repeat_out_o;
    endproperty
    a_repeat_pd: assert property (p_repeat_pd) else $error("repeat on in power-down"); // RL3

    property p_repeat_off;
        @(posedge clk_i) disable iff (rst_i)
        ce_i && (!ctrl_r.ref_repeat_enable || !pll_enable_pin_i) |=> !ref_repeat_out_o;
    endproperty
    a_repeat_off: assert property (p_repeat_off) else $error("repeat not disabled"); // RL2

    property p_repeat_src;
        @(posedge clk_i) disable iff (rst_i)
        ce_i && pll_enable_pin_i && !power_down_pin_i && ctrl_r.ref_repeat_enable
        |=> ref_repeat_out_o == ($past(ref_input_select_pin_i) ? $past(single_ended_ref_in_i)
                                                               : $past(diff_ref_in_i));
    endproperty
    a_repeat_src: assert property (p_repeat_src) else $error("repeat wrong source"); // RL1

    property p_aux_pd;
        @(posedge clk_i) disable iff (rst_i)
        ce_i && power_down_pin_i ##1 ce_i |=> !aux_out_c_o && !aux_out_d_o;
    endproperty
    a_aux_pd: assert property (p_aux_pd) else $error("aux active in power-down"); // RL7

    property p_d_needs_c;
        @(posedge clk_i) disable iff (rst_i)
        ce_i && c_code == 2'h0 |=> d_func_r inside {refclk_out_pkg::AUX_OFF,
                                                    refclk_out_pkg::AUX_OVR};
    endproperty
    a_d_needs_c: assert property (p_d_needs_c) else $error("pin D ref without pin C"); // RL10

    property p_c_strap;
        @(posedge clk_i) disable iff (rst_i)
        ce_i && !power_down_pin_i && !ctrl_r.strap_override_enable
        && clock_config_straps_i == 2'h2 |=> c_func_r == refclk_out_pkg::AUX_REF2;
    endproperty
    a_c_strap: assert property (p_c_strap) else $error("strap decode wrong"); // RL11

    property p_d_strap;
        @(posedge clk_i) disable iff (rst_i)
        ce_i && !power_down_pin_i && !ctrl_r.strap_override_enable
        && clock_config_straps_i == 2'h3 |=> d_func_r == refclk_out_pkg::AUX_REF;
    endproperty
    a_d_strap: assert property (p_d_strap) else $error("pin D strap not undivided"); // RL13

    property p_trig_off;
        @(posedge clk_i) disable iff (rst_i)
        ce_i && !trig_r.enable |=> !trig_clock_out_o;
    endproperty
    a_trig_off: assert property (p_trig_off) else $error("trigger out while off"); // RL5

    property p_trig_wrap;
        @(posedge clk_i) disable iff (rst_i)
        ce_i && trig_r.enable && trig_r.mode != `RCO_TRIG_MODE_TSTAMP && serdes_tick_i
        && trig_r.rx_div != 8'h0 && trig_cnt_r == trig_r.rx_div - 8'h1 |=> trig_cnt_r == 8'h0;
    endproperty
    a_trig_wrap: assert property (p_trig_wrap) else $error("divider wrap wrong"); // RL6

    property p_capture;
        @(posedge clk_i) disable iff (rst_i)
        $past(ce_i) && sysref_capture_o |-> $past(sysref_tap) && !$past(sysref_prev_r);
    endproperty
    a_capture: assert property (p_capture) else $error("capture without edge"); // RL15

endmodule : ref_clock_output_select
`default_nettype wire

/* File: testbench/ref_source.sv */
// Far-side source model: reference clocks, lane ticks and a separate timing reference
`timescale 1ns/1ps
`default_nettype none
module ref_source (
    // Clock and command
    input  wire logic clk_i,
    input  wire logic fire_i,
    // Sources
    output logic      diff_ref_o,
    output logic      se_ref_o,
    output logic      tick_o,
    output logic      sysref_o
);
    logic [3:0] cnt_r = 4'h0;
    logic       pulse_r = 1'b0;
    // The timing reference has its own flop, apart from the repeated clock
    always @(posedge clk_i) begin
        cnt_r   <= cnt_r + 4'h1;
        // Single pulses only, so no periodic rate has to be kept
        pulse_r <= fire_i;
    end
    assign diff_ref_o = cnt_r[1];
    assign se_ref_o   = cnt_r[2];
    assign tick_o     = cnt_r[0];
    assign sysref_o   = pulse_r;
endmodule : ref_source
`default_nettype wire

/* File: testbench/tb.sv */
// Self-checking bench of the clock output select block
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, we = 1'b0, fire = 1'b0;
    logic pll = 1'b1, rsel = 1'b0, pd = 1'b0, ts = 1'b0;
    logic [1:0] strap = 2'h0, ovr = 2'h0;
    logic [7:0] adr = 8'h00;
    logic [31:0] wd = 32'h0, rd, d;
    logic dref, sref, tick, sys, ack, rep, trig, oc, od, cap;
    int n_fail = 0, cmp_count = 0, cyc_n = 0, k, n;
    ref_source src_u (.clk_i(clk_i), .fire_i(fire), .diff_ref_o(dref), .se_ref_o(sref),
        .tick_o(tick), .sysref_o(sys));
    ref_clock_output_select dut_u (.clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1), .cyc_i(cyc),
        .stb_i(cyc), .we_i(we), .adr_i(adr), .sel_i(4'hf), .dat_i(wd), .dat_o(rd), .ack_o(ack),
        .pll_enable_pin_i(pll), .ref_input_select_pin_i(rsel), .power_down_pin_i(pd),
        .clock_config_straps_i(strap), .diff_ref_in_i(dref), .single_ended_ref_in_i(sref),
        .timestamp_in_i(ts), .serdes_tick_i(tick), .sysref_i(sys), .overrange_i(ovr),
        .ref_repeat_out_o(rep), .trig_clock_out_o(trig), .aux_out_c_o(oc), .aux_out_d_o(od),
        .sysref_capture_o(cap));
    initial forever #2.5 clk_i = ~clk_i;
    always @(posedge clk_i) begin
        cyc_n <= cyc_n + 1;
        if (cyc_n == 5000) begin
            n_fail++;
            results();
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected at %0t: got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] v);
        @(posedge clk_i);
        cyc <= 1'b1;
        we <= w;
        adr <= a;
        wd <= v;
        do @(posedge clk_i); while (ack !== 1'b1);
        d = rd;
        cyc <= 1'b0;
        we <= 1'b0;
    endtask : wb
    task automatic st(input int c);
        repeat (c) @(posedge clk_i);
        #1;
    endtask : st
    task automatic low(ref logic s);
        st(2);
        repeat (8) begin
            chk(s, 1'b0);
            st(1);
        end
    endtask : low
    // Rising edges in a window that is a whole number of periods
    task automatic edges(ref logic s, input int e);
        logic p;
        #1;
        p = s;
        n = 0;
        repeat (96) begin
            st(1);
            n += int'(s && !p);
            p = s;
        end
        chk(n, e);
    endtask : edges
    task automatic aux(input logic [7:0] c, input logic [1:0] s, input logic [2:0] ec, ed);
        strap <= s;
        wb(1'b1, 8'h00, {24'h0, c});
        st(3);
        wb(1'b0, 8'h0c, 32'h0);
        chk({26'h0, d[6:4], d[3:1]}, {26'h0, ed, ec});
    endtask : aux
    task automatic results;
        $display("mismatches %0d compares %0d", n_fail, cmp_count);
        if (n_fail == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : results
    initial begin
        repeat (6) @(posedge clk_i);
        rst_i <= 1'b0;
        wb(1'b0, 8'h00, 32'h0);
        chk(d, 32'h1);
        wb(1'b0, 8'h04, 32'h0);
        chk(d, 32'h400);
        low(trig);
        for (k = 0; k < 32; k++) begin
            rsel <= (k > 15);
            n = (k > 15) ? sref : dref;
            st(1);
            chk(rep, n);
        end
        rsel <= 1'b0;
        wb(1'b1, 8'h00, 32'h0);
        low(rep);
        wb(1'b1, 8'h00, 32'h1);
        pll <= 1'b0;
        low(rep);
        pll <= 1'b1;
        ovr <= 2'b01;
        aux(8'h05, 2'd0, 3'd1, 3'd1);
        chk({oc, od}, 2'b10);
        aux(8'h01, 2'd0, 3'd0, 3'd0);
        for (k = 1; k < 4; k++) begin
            aux(8'h05, k[1:0], 3'(k + 1), 3'd2);
            edges(oc, 24 >> (k - 1));
            edges(od, 24);
        end
        for (k = 0; k < 4; k++) aux(8'h07 | 8'(k * 8'h50), 2'd0, 3'(k ? k + 1 : 1), 3'(k ? k + 1 : 1));
        aux(8'h47, 2'd3, 3'd1, 3'd1);
        aux(8'h01, 2'd1, 3'd2, 3'd2);
        pd <= 1'b1;
        low(rep);
        low(oc);
        low(od);
        pd <= 1'b0;
        wb(1'b1, 8'h04, 32'h601);
        edges(trig, 8);
        wb(1'b1, 8'h04, 32'h607);
        @(posedge clk_i);
        ts <= 1'b1;
        st(1);
        chk(trig, 1'b0);
        st(1);
        chk(trig, 1'b1);
        @(posedge clk_i);
        fire <= 1'b1;
        @(posedge clk_i);
        fire <= 1'b0;
        edges(cap, 1);
        wb(1'b0, 8'h0c, 32'h0);
        chk(d[23:16], 8'h01);
        wb(1'b1, 8'h08, 32'h3);
        @(posedge clk_i);
        fire <= 1'b1;
        @(posedge clk_i);
        fire <= 1'b0;
        st(4);
        chk(cap, 1'b0);
        st(1);
        chk(cap, 1'b1);
        wb(1'b0, 8'h10, 32'h0);
        chk(d, 32'h0);
        results();
    end
endmodule : tb
`default_nettype wire
